// >>> verilog/blzc_pkg.sv
// Constants for the indoor and dark zone backlight current register bank.
// Assumes an 8-bit register port from the serial host interface, byte addresses.
package blzc_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    localparam int CODE_W = 7;
    localparam logic [7:0] INDOOR_MAX_OFS = 8'h10;
    localparam logic [7:0] INDOOR_DIM_OFS = 8'h11;
    localparam logic [7:0] DARK_MAX_OFS = 8'h12;
    localparam logic [7:0] DARK_DIM_OFS = 8'h13;
    localparam int CODE_LSB = 0;
    localparam int CODE_MSB = 6;
    localparam int RSVD_BIT = 7;
    localparam logic [6:0] CODE_RESET = 7'h00;
    localparam logic [6:0] CODE_OFF = 7'h00;
    localparam logic [6:0] CODE_FULL = 7'h7f;
    localparam logic [7:0] READ_UNMAPPED = 8'h00;
    typedef enum logic [1:0] {
        ZONE_OTHER,
        ZONE_INDOOR,
        ZONE_DARK
    } blzc_zone_t;
endpackage : blzc_pkg

// >>> verilog/blzc_bus_if.sv
// Register-port signals passed from the bank top to its code storage.
// Assumes one clock domain and single-cycle write strobes.
`timescale 1ns/1ps
`default_nettype none
interface blzc_bus_if;
    logic wr_en;
    logic [7:0] addr;
    logic [6:0] wr_code;
    logic [6:0] indoor_full_code;
    logic [6:0] indoor_dimmed_code;
    logic [6:0] dark_full_code;
    logic [6:0] dark_dimmed_code;
    modport bank (
        input wr_en, addr, wr_code,
        output indoor_full_code, indoor_dimmed_code, dark_full_code, dark_dimmed_code
    );
    modport top (
        output wr_en, addr, wr_code,
        input indoor_full_code, indoor_dimmed_code, dark_full_code, dark_dimmed_code
    );
endinterface : blzc_bus_if
`default_nettype wire

// >>> verilog/blzc_code_bank.sv
// Four 7-bit current code registers for the indoor and dark zones.
// Assumes writes arrive already decoded to a strobe, an address and a code.
`timescale 1ns/1ps
`default_nettype none
module blzc_code_bank (
    input wire logic mclk,
    input wire logic reset_n,
    blzc_bus_if.bank bus
);
    logic [6:0] im_q, im_d, id_q, id_d, dm_q, dm_d, dd_q, dd_d;

    always_comb begin
        im_d = im_q;
        id_d = id_q;
        dm_d = dm_q;
        dd_d = dd_q;
        if (bus.wr_en) begin
            if (bus.addr == blzc_pkg::INDOOR_MAX_OFS) begin
                im_d = bus.wr_code;
            end else if (bus.addr == blzc_pkg::INDOOR_DIM_OFS) begin
                id_d = bus.wr_code;
            end else if (bus.addr == blzc_pkg::DARK_MAX_OFS) begin
                dm_d = bus.wr_code;
            end else if (bus.addr == blzc_pkg::DARK_DIM_OFS) begin
                dd_d = bus.wr_code;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            im_q <= blzc_pkg::CODE_RESET;
            id_q <= blzc_pkg::CODE_RESET;
            dm_q <= blzc_pkg::CODE_RESET;
            dd_q <= blzc_pkg::CODE_RESET;
        end else begin
            im_q <= im_d;
            id_q <= id_d;
            dm_q <= dm_d;
            dd_q <= dd_d;
        end
    end

    assign bus.indoor_full_code = im_q;
    assign bus.indoor_dimmed_code = id_q;
    assign bus.dark_full_code = dm_q;
    assign bus.dark_dimmed_code = dd_q;
endmodule : blzc_code_bank
`default_nettype wire

// >>> verilog/blzc_regs.sv
// Indoor and dark zone backlight current registers with code selection.
// Assumes host port signals and zone and dim inputs are on mclk already.
// Assumes at most one read or write strobe per cycle from the host port.
//
// Behaviour
// - Indoor full code at 0x10, bits 6:0
// - Indoor dimmed code at 0x11, used when dimming
// - Dark full code at 0x12, bits 6:0
// - Dark dimmed code at 0x13, used when dimming
// - Code zero is off, all ones full current

`timescale 1ns/1ps
`default_nettype none
module blzc_regs (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire blzc_pkg::blzc_zone_t zone_sel,
    input wire logic dim_timeout,
    input wire logic dim_flag,
    output logic [7:0] reg_rdata,
    output logic reg_rvalid,
    output logic [6:0] led_code,
    output logic led_off,
    output logic led_full,
    output logic zone_active
);
    blzc_bus_if bus ();

    // Read path state
    logic [7:0] rdata_q;
    logic [7:0] rdata_d;
    logic rvalid_q;
    logic rvalid_d;
    // Code path and flag state
    logic [6:0] code_q;
    logic [6:0] code_d;
    logic off_q;
    logic off_d;
    logic full_q;
    logic full_d;
    logic act_q;
    logic act_d;
    // Decoded address, zone and dim level
    logic hit_indoor_max;
    logic hit_indoor_dim;
    logic hit_dark_max;
    logic hit_dark_dim;
    logic map_hit;
    logic wr_en;
    logic zone_indoor;
    logic zone_dark;
    logic dimmed;
    logic [6:0] indoor_code;
    logic [6:0] dark_code;

    // Address decode, shared by reads and writes
    always_comb begin
        hit_indoor_max = 1'h0;
        hit_indoor_dim = 1'h0;
        hit_dark_max = 1'h0;
        hit_dark_dim = 1'h0;
        if (reg_addr == blzc_pkg::INDOOR_MAX_OFS) begin
            hit_indoor_max = 1'h1;
        end else if (reg_addr == blzc_pkg::INDOOR_DIM_OFS) begin
            hit_indoor_dim = 1'h1;
        end else if (reg_addr == blzc_pkg::DARK_MAX_OFS) begin
            hit_dark_max = 1'h1;
        end else if (reg_addr == blzc_pkg::DARK_DIM_OFS) begin
            hit_dark_dim = 1'h1;
        end
    end

    // Unmapped offsets never reach the bank
    assign map_hit = hit_indoor_max | hit_indoor_dim | hit_dark_max | hit_dark_dim;

    always_comb begin
        wr_en = 1'h0;
        if (reg_wr && map_hit) begin
            wr_en = 1'h1;
        end
    end

    // Write port into the code bank
    assign bus.wr_en = wr_en;
    assign bus.addr = reg_addr;
    // Reserved bit dropped at the port, so storage cannot hold it
    assign bus.wr_code = reg_wdata[blzc_pkg::CODE_MSB:blzc_pkg::CODE_LSB];

    blzc_code_bank u_bank (
        .mclk(mclk),
        .reset_n(reset_n),
        .bus(bus)
    );

    // Read data holds its last value between reads
    always_comb begin
        rdata_d = rdata_q;
        if (reg_rd) begin
            if (hit_indoor_max) begin
                rdata_d = {1'h0, bus.indoor_full_code};
            end else if (hit_indoor_dim) begin
                rdata_d = {1'h0, bus.indoor_dimmed_code};
            end else if (hit_dark_max) begin
                rdata_d = {1'h0, bus.dark_full_code};
            end else if (hit_dark_dim) begin
                rdata_d = {1'h0, bus.dark_dimmed_code};
            end else begin
                // Unmapped reads still answer, so the host never stalls
                rdata_d = blzc_pkg::READ_UNMAPPED;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            rdata_q <= blzc_pkg::READ_UNMAPPED;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    // Valid pulses once, one cycle after the strobe
    always_comb begin
        rvalid_d = reg_rd;
    end

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            rvalid_q <= 1'h0;
        end else begin
            rvalid_q <= rvalid_d;
        end
    end

    // Other zone values belong to other banks
    always_comb begin
        zone_indoor = 1'h0;
        zone_dark = 1'h0;
        case (zone_sel)
            blzc_pkg::ZONE_INDOOR: begin
                zone_indoor = 1'h1;
            end
            blzc_pkg::ZONE_DARK: begin
                zone_dark = 1'h1;
            end
            default: begin
                zone_indoor = 1'h0;
                zone_dark = 1'h0;
            end
        endcase
    end

    // Either dim source selects the dimmed code
    always_comb begin
        dimmed = 1'h0;
        if (dim_timeout || dim_flag) begin
            dimmed = 1'h1;
        end
    end

    // Full or dimmed code per zone
    always_comb begin
        if (dimmed) begin
            indoor_code = bus.indoor_dimmed_code;
            dark_code = bus.dark_dimmed_code;
        end else begin
            indoor_code = bus.indoor_full_code;
            dark_code = bus.dark_full_code;
        end
    end

    // No current when no zone of this bank is active
    always_comb begin
        if (zone_indoor) begin
            code_d = indoor_code;
        end else if (zone_dark) begin
            code_d = dark_code;
        end else begin
            code_d = blzc_pkg::CODE_OFF;
        end
    end

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            code_q <= blzc_pkg::CODE_OFF;
        end else begin
            code_q <= code_d;
        end
    end

    // Flags come from the same next code, so they never disagree with it
    always_comb begin
        act_d = zone_indoor | zone_dark;
        // Nonlinear scale itself lives in the analog sink; only end points flagged
        off_d = (code_d == blzc_pkg::CODE_OFF);
        full_d = (code_d == blzc_pkg::CODE_FULL);
    end

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            off_q <= 1'h1;
            full_q <= 1'h0;
            act_q <= 1'h0;
        end else begin
            off_q <= off_d;
            full_q <= full_d;
            act_q <= act_d;
        end
    end

    // Outputs straight from flip-flops
    assign reg_rdata = rdata_q;
    assign reg_rvalid = rvalid_q;
    assign led_code = code_q;
    assign led_off = off_q;
    assign led_full = full_q;
    assign zone_active = act_q;
endmodule : blzc_regs
`default_nettype wire

// >>> dv/blzc_regs_chk.sv
// Port checker for the zone current register bank.
// Assumes bound to blzc_regs, one mclk domain.
`timescale 1ns/1ps
`default_nettype none
module blzc_chk (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire blzc_pkg::blzc_zone_t zone_sel,
    input wire logic dim_timeout,
    input wire logic dim_flag,
    input wire logic [7:0] reg_rdata,
    input wire logic reg_rvalid,
    input wire logic [6:0] led_code,
    input wire logic led_off,
    input wire logic led_full,
    input wire logic zone_active
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!reset_n);
    // Write, then selection one cycle on: code shows two edges after the write
    property p_sel(a, z, d);
        reg_wr && reg_addr == a ##1 !reg_wr && zone_sel == z && (dim_flag | dim_timeout) == d
            |=> led_code == $past(reg_wdata[6:0], 2);
    endproperty
    chk_indoor_full: assert property (p_sel(8'h10, blzc_pkg::ZONE_INDOOR, 1'h0))
        else $error("indoor full code");
    chk_indoor_dim: assert property (p_sel(8'h11, blzc_pkg::ZONE_INDOOR, 1'h1))
        else $error("indoor dim code");
    chk_dark_full: assert property (p_sel(8'h12, blzc_pkg::ZONE_DARK, 1'h0))
        else $error("dark full code");
    chk_dark_dim: assert property (p_sel(8'h13, blzc_pkg::ZONE_DARK, 1'h1))
        else $error("dark dim code");
    chk_end_flags: assert property (led_off == (led_code == 7'h00) && led_full == (led_code == 7'h7f))
        else $error("end point flags");
    chk_rsvd_zero: assert property (reg_rvalid |-> !reg_rdata[7])
        else $error("reserved bit set");
    // Back-to-back reads are legal, so each strobe is checked on its own
    chk_read_lat: assert property (reg_rd |=> reg_rvalid)
        else $error("read valid timing");
    chk_rvalid_idle: assert property (!reg_rd |=> !reg_rvalid)
        else $error("read valid without strobe");
    chk_zone_act: assert property (1'h1 |=> zone_active == $past(zone_sel inside {2'h1, 2'h2}))
        else $error("zone active");
    cover property (led_full);
    cover property (reg_rvalid && reg_rdata == 8'h7f);
    cover property (zone_active && dim_flag ##1 !led_off);
endmodule : blzc_chk
bind blzc_regs blzc_chk u_chk (
    .mclk(mclk),
    .reset_n(reset_n),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .zone_sel(zone_sel),
    .dim_timeout(dim_timeout),
    .dim_flag(dim_flag),
    .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid),
    .led_code(led_code),
    .led_off(led_off),
    .led_full(led_full),
    .zone_active(zone_active)
);
`default_nettype wire

// >>> dv/backlight_zone_current_regs_test.sv
// Self-checking bench for the zone current register bank.
// Assumes the bank alone on mclk; reads checked from a queue.
`timescale 1ns/1ps
`default_nettype none
module backlight_zone_current_regs_test;
    logic mclk = 1'h0, reset_n = 1'h0, reg_wr = 1'h0, reg_rd = 1'h0;
    logic dim_timeout = 1'h0, dim_flag = 1'h0, reg_rvalid, led_off, led_full, zone_active;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, a, d;
    logic [6:0] led_code;
    blzc_pkg::blzc_zone_t zone_sel = blzc_pkg::ZONE_OTHER;
    // Note layout: zone_active, led_full, led_off, led_code, reg_rdata
    logic [17:0] exp_q[$];
    logic [17:0] exp_v, got_v;
    // Reference codes: indoor full, indoor dim, dark full, dark dim
    logic [6:0] m[4] = '{default: 7'h00};
    int error_cnt = 0, samples_checked = 0;
    blzc_regs DUT (.mclk, .reset_n, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .zone_sel,
        .dim_timeout, .dim_flag, .reg_rdata, .reg_rvalid, .led_code, .led_off, .led_full,
        .zone_active);
    assign got_v = {zone_active, led_full, led_off, led_code, reg_rdata};
    initial forever #4 mclk = ~mclk;
    task automatic summarize;
        $display("errors %0d checks %0d", error_cnt, samples_checked);
        if (error_cnt == 0 && samples_checked > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : summarize
    // Expected outputs from the reference codes and the present zone and dim levels
    function automatic logic [17:0] exp_out(input logic [7:0] rb);
        logic [6:0] c;
        logic dm;
        c = 7'h00;
        dm = dim_flag | dim_timeout;
        if (zone_sel == blzc_pkg::ZONE_INDOOR) c = m[{1'h0, dm}];
        else if (zone_sel == blzc_pkg::ZONE_DARK) c = m[{1'h1, dm}];
        return {zone_sel == blzc_pkg::ZONE_INDOOR || zone_sel == blzc_pkg::ZONE_DARK,
            c == 7'h7f, c == 7'h00, c, rb};
    endfunction : exp_out
    task automatic wr(input logic [7:0] wa, input logic [7:0] wd);
        @(posedge mclk);
        reg_wr <= 1'h1;
        reg_addr <= wa;
        reg_wdata <= wd;
        if (wa >= 8'h10 && wa <= 8'h13) m[wa[1:0]] = wd[6:0];
        @(posedge mclk);
        reg_wr <= 1'h0;
    endtask : wr
    task automatic rd(input logic [7:0] ra, input logic [7:0] re);
        @(posedge mclk);
        reg_rd <= 1'h1;
        reg_addr <= ra;
        exp_q.push_back(exp_out(re));
        @(posedge mclk);
        reg_rd <= 1'h0;
    endtask : rd
    // Monitor: oldest note against each returned byte
    always @(posedge mclk) begin
        if (reg_rvalid === 1'h1 && exp_q.size() == 0) begin
            error_cnt++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got_v, 18'h00000);
        end else if (reg_rvalid === 1'h1) begin
            exp_v = exp_q.pop_front();
            samples_checked++;
            if (got_v !== exp_v) begin
                error_cnt++;
                $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got_v, exp_v);
            end
        end
    end
    initial begin
        repeat (2000) @(posedge mclk);
        error_cnt++;
        summarize();
    end
    initial begin
        void'($urandom(40));
        repeat (4) @(posedge mclk);
        reset_n <= 1'h1;
        for (int i = 0; i < 5; i++) rd(8'h10 + 8'(i), 8'h00);
        // Ends of the scale first, then random codes with bit 7 noise
        for (int i = 0; i < 32; i++) begin
            a = 8'h10 + 8'(i[1:0]);
            d = i < 4 ? 8'h80 : i < 8 ? 8'hff : 8'($urandom);
            wr(a, d);
            zone_sel <= i[4] ? blzc_pkg::blzc_zone_t'(i[1:0])
                : a[1] ? blzc_pkg::ZONE_DARK : blzc_pkg::ZONE_INDOOR;
            dim_flag <= a[0] & i[2];
            dim_timeout <= a[0] & ~i[2];
            rd(a, {1'h0, d[6:0]});
        end
        wr(8'h14, 8'h7f);
        rd(8'h13, {1'h0, d[6:0]});
        rd(8'h14, 8'h00);
        // Mid-run reset, then the dark dimmed code at 0x13 must read back as zero
        reset_n <= 1'h0;
        repeat (2) @(posedge mclk);
        reset_n <= 1'h1;
        m = '{default: 7'h00};
        rd(8'h13, 8'h00);
        repeat (4) @(posedge mclk);
        if (exp_q.size() != 0) error_cnt++;
        summarize();
    end
endmodule : backlight_zone_current_regs_test
`default_nettype wire
